// ==== src/logic_judge_trigger.sv ====
// Logic pattern and waveform judgment trigger with noise filter.
// Assumes logic pins are asynchronous and analog samples arrive on clk.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module logic_judge_trigger
#(
   parameter logic [trig_pkg::CNT_W-1:0] RT_FILT_CYC =
      trig_pkg::CNT_W'(trig_pkg::RT_FILT_NS / trig_pkg::CLK_PERIOD_NS)
)
(
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // Avalon-MM slave
   input  wire logic [trig_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [trig_pkg::DATA_W-1:0]   avs_writedata,
   output logic      [trig_pkg::DATA_W-1:0]   avs_readdata,
   output logic                               avs_waitrequest,
   // Logic probe pins
   input  wire logic [trig_pkg::N_CH-1:0]     logic_in,
   // Analog sample stream
   input  wire logic                          sample_valid,
   input  wire logic [trig_pkg::SMP_W-1:0]    sample_data,
   // Trigger event
   output logic                               trigger
);
   import trig_pkg::*;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_q;
   logic       rst_n;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // ---------------------------------------------------------------
   // Registers and bus slave
   // ---------------------------------------------------------------
   bus_state_t        state;
   bus_state_t        next_state;
   logic [15:0]       ctrl;
   logic [N_CH-1:0]   level;
   logic [N_CH-1:0]   care;
   logic [SMP_W-1:0]  range;
   logic [REF_AW-1:0] ref_wptr;
   logic [15:0]       trig_cnt;
   logic              pat_met;
   logic              judge_hit;
   logic              armed;
   logic [DATA_W-1:0] rd_mux;

   wire in_idle = (state == BUS_IDLE);
   wire in_ans  = (state == BUS_ANS);
   wire wr_go   = in_ans & avs_write;
   wire rd_go   = in_idle & avs_read;
   wire wr_ctrl = wr_go & (avs_address == REG_CTRL);
   wire wr_lvl  = wr_go & (avs_address == REG_LEVEL);
   wire wr_care = wr_go & (avs_address == REG_CARE);
   wire wr_rng  = wr_go & (avs_address == REG_RANGE);
   wire wr_rptr = wr_go & (avs_address == REG_REF_ADDR);
   wire wr_rdat = wr_go & (avs_address == REG_REF_DATA);

   assign next_state = (in_idle & (avs_read | avs_write)) ? BUS_ANS
                                                          : BUS_IDLE;

   always_comb
   begin
      rd_mux = '0;
      case (avs_address)
         REG_CTRL:     rd_mux[15:0] = ctrl;
         REG_LEVEL:    rd_mux[N_CH-1:0] = level;
         REG_CARE:     rd_mux[N_CH-1:0] = care;
         REG_RANGE:    rd_mux[SMP_W-1:0] = range;
         REG_REF_ADDR: rd_mux[REF_AW-1:0] = ref_wptr;
         REG_STATUS:
         begin
            rd_mux[STAT_PAT] = pat_met;
            rd_mux[STAT_JUDGE] = judge_hit;
            rd_mux[STAT_ARMED] = armed;
            rd_mux[STAT_CNT_LSB +: 16] = trig_cnt;
         end
         default:      rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end
      else
      begin
         state <= next_state;
         avs_waitrequest <= (next_state != BUS_ANS);
         if (rd_go)
            avs_readdata <= rd_mux;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= CTRL_RESET;
         level <= '0;
         care <= '0;
         range <= '0;
         ref_wptr <= '0;
      end
      else
      begin
         if (wr_ctrl) ctrl <= avs_writedata[15:0];
         if (wr_lvl) level <= avs_writedata[N_CH-1:0];
         if (wr_care) care <= avs_writedata[N_CH-1:0];
         if (wr_rng) range <= avs_writedata[SMP_W-1:0];
         if (wr_rptr)
            ref_wptr <= avs_writedata[REF_AW-1:0];
         else if (wr_rdat)
            ref_wptr <= ref_wptr + 1'b1;
      end
   end

   cond_t            cond;
   wire              judge_en = ctrl[CTRL_JUDGE];
   wire              rt_mode  = ctrl[CTRL_RT];
   wire              rt_filt  = ctrl[CTRL_RT_FILT];
   wire              instantaneous_input_mode = ctrl[CTRL_INST];
   wire              ivl10    = ctrl[CTRL_IVL10];
   wire [2:0]        filt_sel = ctrl[CTRL_FILT_LSB +: 3];
   wire [3:0]        tb       = ctrl[CTRL_TB_LSB +: 4];
   assign cond = cond_t'(ctrl[CTRL_COND_LSB +: 2]);

   // ---------------------------------------------------------------
   // Logic pattern
   // ---------------------------------------------------------------
   logic [N_CH-1:0] s1, s2, s3, lvl_in;
   logic [N_CH-1:0] ch_hit, ch_ok;

   // Third stage filters metastable glitches before use
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         lvl_in <= '0;
      end
      else
      begin
         s1 <= logic_in;
         s2 <= s1;
         s3 <= s2;
         lvl_in <= (s2 ^ s3) & lvl_in | ~(s2 ^ s3) & s3;
      end
   end

   for (genvar g = 0; g < N_CH; g++)
   begin : g_ch
      wire match = (lvl_in[g] == level[g]);
      assign ch_hit[g] = care[g] & match;
      assign ch_ok[g]  = ~care[g] | match;
   end

   // AND with nothing considered is never met
   wire pat_or  = |ch_hit;
   wire pat_and = (&ch_ok) & (|care);
   wire next_pat = (cond == COND_OR)  ? pat_or :
                   (cond == COND_AND) ? pat_and : 1'b0;

   // ---------------------------------------------------------------
   // Waveform judgment
   // ---------------------------------------------------------------
   ref_mem_if mif ();
   logic [7:0]        gap;
   logic [11:0]       tick_cnt;
   logic              prev_neg;
   logic [REF_AW-1:0] idx;
   logic [SMP_W-1:0]  last_smp;
   logic              tick_d;

   wire judge_ok = judge_en & instantaneous_input_mode & ~rt_mode
                   & (tb <= TB_MAX);
   wire smp_acc  = sample_valid & (gap >= 8'(SMP_MIN_CYC - 1));
   wire zc       = smp_acc & prev_neg & ~sample_data[SMP_W-1];
   wire fast_tb  = (tb <= TB_FAST_MAX);
   wire tick_end = (tick_cnt == 12'(JUDGE_CYC - 1));
   wire tick     = judge_ok & (fast_tb ? (tick_end | zc)
                                       : smp_acc);
   wire [REF_AW-1:0] next_idx = zc ? '0 : idx + 1'b1;

   assign mif.wr_en   = wr_rdat;
   assign mif.wr_addr = ref_wptr;
   assign mif.wr_data = avs_writedata[SMP_W-1:0];
   assign mif.rd_en   = tick;
   assign mif.rd_addr = next_idx;

   ref_wave_mem u_ref
   (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (mif.mem)
   );

   // Envelope in 18 bits so the range cannot wrap the reference
   wire signed [17:0] ref_x = {{2{mif.rd_data[SMP_W-1]}}, mif.rd_data};
   wire signed [17:0] rng_x = {2'h0, range};
   wire signed [17:0] smp_x = {{2{last_smp[SMP_W-1]}}, last_smp};
   wire signed [17:0] env_hi = ref_x + rng_x;
   wire signed [17:0] env_lo = ref_x - rng_x;
   wire outside = (smp_x > env_hi) | (smp_x < env_lo);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap <= '0;
         tick_cnt <= '0;
         prev_neg <= 1'b0;
         idx <= '0;
         last_smp <= '0;
         armed <= 1'b0;
         tick_d <= 1'b0;
         judge_hit <= 1'b0;
      end
      else
      begin
         if (smp_acc)
            gap <= '0;
         else if (gap != 8'hff)
            gap <= gap + 1'b1;
         tick_cnt <= (tick_end | zc) ? '0 : tick_cnt + 1'b1;
         if (smp_acc)
         begin
            prev_neg <= sample_data[SMP_W-1];
            last_smp <= sample_data;
         end
         if (tick)
            idx <= next_idx;
         if (!judge_ok)
            armed <= 1'b0;
         else if (zc)
            armed <= 1'b1;
         tick_d <= tick;
         if (!judge_ok)
            judge_hit <= 1'b0;
         else if (tick_d)
            judge_hit <= armed & outside;
      end
   end

   // ---------------------------------------------------------------
   // Noise filter and trigger
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] need;
   logic             fired;

   wire cond_now = pat_met | judge_hit;
   wire filt_on  = rt_mode ? rt_filt : (filt_sel != 3'h0);
   // Fixed 10 ms width counts clocks, all other widths count samples
   wire per_clk  = rt_mode & ~ivl10;
   wire step     = per_clk | sample_valid;
   assign need = !rt_mode ? CNT_W'(filt_len(filt_sel)) :
                 ivl10    ? RT_IVL_SMP : RT_FILT_CYC;
   wire qual = cond_now & (~filt_on | (cnt >= need));

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pat_met <= 1'b0;
         cnt <= '0;
         fired <= 1'b0;
         trigger <= 1'b0;
         trig_cnt <= '0;
      end
      else
      begin
         pat_met <= next_pat;
         if (!cond_now)
            cnt <= '0;
         else if (step & (cnt < need))
            cnt <= cnt + 1'b1;
         fired <= qual;
         trigger <= qual & ~fired;
         if (qual & ~fired)
            trig_cnt <= trig_cnt + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_req;
      in_idle & (avs_read | avs_write);
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_qualify;
      cond_now & filt_on & ~fired ##1 trigger;
   endsequence

   a_bus_answer: assert property (s_req |=> s_answer)
      else $error("bus answer not one cycle after request");
   a_high_match: assert property (cond == COND_OR && care[0]
      && level[0] && lvl_in[0] |=> pat_met)
      else $error("high entry did not match high input");
   a_low_match: assert property (cond == COND_OR && care[0]
      && !level[0] && !lvl_in[0] |=> pat_met)
      else $error("low entry did not match low input");
   // Only cared inputs held; ignored ones may toggle freely
   a_ignore_chan: assert property ($stable(lvl_in & care)
      && $stable(ctrl) && $stable(care) && $stable(level)
      |=> $stable(pat_met))
      else $error("ignored channel changed the pattern");
   a_and_all: assert property (cond == COND_AND && !(&ch_ok)
      |=> !pat_met)
      else $error("AND met with a channel mismatched");
   a_off_never: assert property (cond == COND_OFF [*2]
      |-> !pat_met)
      else $error("pattern met with condition off");
   a_filt_full: assert property (s_qualify
      |-> $past(cnt) >= $past(need))
      else $error("trigger before filter width reached");
   a_judge_gate: assert property (!judge_ok |=> !judge_hit)
      else $error("judgment active while not allowed");
   a_zero_align: assert property (zc && judge_ok |=> idx == '0)
      else $error("reference not realigned on zero crossing");
   a_trig_pulse: assert property (trigger |=> !trigger)
      else $error("trigger longer than one cycle");

endmodule : logic_judge_trigger

// ==== src/ref_mem_if.sv ====
// Port bundle between the trigger core and its reference memory.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ref_mem_if;
   import trig_pkg::*;
   logic              wr_en;
   logic [REF_AW-1:0] wr_addr;
   logic [SMP_W-1:0]  wr_data;
   logic              rd_en;
   logic [REF_AW-1:0] rd_addr;
   logic [SMP_W-1:0]  rd_data;
   modport core (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 output rd_data);
endinterface : ref_mem_if

// ==== src/ref_wave_mem.sv ====
// Reference waveform store: one write port, one registered read port.
// Assumes the synchronised reset of the trigger core.
`timescale 1ns/1ps
module ref_wave_mem
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Memory port
   ref_mem_if.mem   port
);
   import trig_pkg::*;

   logic [SMP_W-1:0] store [0:(1<<REF_AW)-1];

   // Contents carry no reset; only the read register does
   always_ff @(posedge clk)
   begin
      if (port.wr_en)
      begin
         store[port.wr_addr] <= port.wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port.rd_data <= '0;
      end
      else if (port.rd_en)
      begin
         port.rd_data <= store[port.rd_addr];
      end
   end

endmodule : ref_wave_mem

// ==== src/trig_pkg.sv ====
// Constants, register map and types for the logic/judgment trigger.
// Assumes a 100 MHz sampling clock and word-addressed Avalon-MM access.
package trig_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int JUDGE_PERIOD_NS = 20_000;
   localparam int JUDGE_CYC = JUDGE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int RT_FILT_NS = 10_000_000;
   localparam int SMP_MIN_NS = 1_000;
   localparam int SMP_MIN_CYC = SMP_MIN_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int N_CH = 16;
   localparam int SMP_W = 16;
   localparam int REF_AW = 10;
   localparam int CNT_W = 20;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 32;

   // ---------------------------------------------------------------
   // Register indices (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] REG_LEVEL = 3'h1;
   localparam logic [ADDR_W-1:0] REG_CARE = 3'h2;
   localparam logic [ADDR_W-1:0] REG_RANGE = 3'h3;
   localparam logic [ADDR_W-1:0] REG_REF_ADDR = 3'h4;
   localparam logic [ADDR_W-1:0] REG_REF_DATA = 3'h5;
   localparam logic [ADDR_W-1:0] REG_STATUS = 3'h6;

   // Control fields
   localparam int CTRL_COND_LSB = 0;
   localparam int CTRL_JUDGE = 2;
   localparam int CTRL_RT = 3;
   localparam int CTRL_RT_FILT = 4;
   localparam int CTRL_INST = 5;
   localparam int CTRL_IVL10 = 6;
   localparam int CTRL_FILT_LSB = 8;
   localparam int CTRL_TB_LSB = 12;
   localparam logic [15:0] CTRL_RESET = 16'h0001;

   // Status fields
   localparam int STAT_PAT = 0;
   localparam int STAT_JUDGE = 1;
   localparam int STAT_ARMED = 2;
   localparam int STAT_CNT_LSB = 16;

   // Time base codes: 0 = 100 us/div ... 4 = 2 ms/div ... 7 = 20 ms/div
   localparam logic [3:0] TB_FAST_MAX = 4'h4;
   localparam logic [3:0] TB_MAX = 4'h7;
   localparam logic [CNT_W-1:0] RT_IVL_SMP = 20'h00002;

   typedef enum logic [1:0] {
      COND_OFF = 2'h0,
      COND_OR  = 2'h1,
      COND_AND = 2'h2
   } cond_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ANS  = 2'b10
   } bus_state_t;

   // Sample-count filter lengths; code 0 is off
   function automatic logic [10:0] filt_len(input logic [2:0] sel);
      case (sel)
         3'h1:    filt_len = 11'h00a;
         3'h2:    filt_len = 11'h014;
         3'h3:    filt_len = 11'h032;
         3'h4:    filt_len = 11'h064;
         3'h5:    filt_len = 11'h0c8;
         3'h6:    filt_len = 11'h1f4;
         3'h7:    filt_len = 11'h3e8;
         default: filt_len = 11'h000;
      endcase
   endfunction : filt_len

endpackage : trig_pkg

// ==== test/probe_src.sv ====
// Behavioural logic probe pins and analog sample source.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module probe_src
(
   // Clock
   input  wire logic                       clk,
   // Probe pins and sample stream
   output logic [trig_pkg::N_CH-1:0]      logic_in,
   output logic                           sample_valid,
   output logic [trig_pkg::SMP_W-1:0]     sample_data
);
   import trig_pkg::*;

   initial
   begin
      logic_in     = '0;
      sample_valid = 1'b0;
      sample_data  = '0;
   end

   task automatic set_pins(input logic [N_CH-1:0] v);
      @(posedge clk);
      logic_in <= v;
   endtask : set_pins

   // One sample pulse, then idle for the rest of the gap
   task automatic send(input logic [SMP_W-1:0] d, input int gap);
      int i;
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_data  <= d;
      @(posedge clk);
      sample_valid <= 1'b0;
      // Stale data must not look valid
      sample_data  <= ~d;
      for (i = 1; i < gap; i++)
         @(posedge clk);
   endtask : send
endmodule : probe_src

// ==== test/tb_logic_judge_trigger.sv ====
// Self-checking bench for the logic pattern and judgment trigger.
// Assumes probe_src drives the pins and the sample stream.
`timescale 1ns/1ps
module tb_logic_judge_trigger;
   import trig_pkg::*;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] RT_CYC = 20'h00028;
   localparam int GAP = SMP_MIN_CYC + 20;
   logic              clk;
   logic              reset_n;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [DATA_W-1:0] avs_writedata;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   logic [N_CH-1:0]   logic_in;
   logic              sample_valid;
   logic [SMP_W-1:0]  sample_data;
   logic              trigger;
   int                err_count;
   int                samples_checked;
   int                trig_cnt;
   int                lens [7];

   logic_judge_trigger #(.RT_FILT_CYC(RT_CYC)) u_dut
   (
      .clk             (clk),
      .reset_n         (reset_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .logic_in        (logic_in),
      .sample_valid    (sample_valid),
      .sample_data     (sample_data),
      .trigger         (trigger)
   );
   probe_src u_src
   (
      .clk          (clk),
      .logic_in     (logic_in),
      .sample_valid (sample_valid),
      .sample_data  (sample_data)
   );

   initial
   begin
      clk = 1'b0;
      trig_cnt = 0;
   end
   always #5 clk = ~clk;
   always @(posedge clk)
      if (trigger === 1'b1)
         trig_cnt <= trig_cnt + 1;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task give_verdict();
      $display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_n

   // Held until the edge that sees waitrequest low
   task automatic bus(input logic we, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rd);
      int n;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= we;
      avs_read      <= ~we;
      n = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 20)
      begin
         $display("[ERR] bus answer expected within 20 seen none");
         err_count++;
         give_verdict();
      end
   endtask : bus

   task automatic send_n(input logic [SMP_W-1:0] d, input int n,
                         input int gap);
      repeat (n) u_src.send(d, gap);
   endtask : send_n

   task automatic chk_trig(input string what, input int exp);
      chk(what, 32'(exp), 32'(trig_cnt));
   endtask : chk_trig

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic scen_reset();
      logic [31:0] d;
      chk("waitrequest idle", 32'h1, {31'h0, avs_waitrequest});
      chk("trigger idle", 32'h0, {31'h0, trigger});
      bus(1'b0, REG_CTRL, 32'h0, d);
      chk("ctrl reset", {16'h0, CTRL_RESET}, d);
      bus(1'b1, 3'h7, 32'hffff_ffff, d);
      bus(1'b0, 3'h7, 32'h0, d);
      chk("unmapped read", 32'h0, d);
      bus(1'b0, REG_REF_DATA, 32'h0, d);
      chk("ref data read", 32'h0, d);
   endtask : scen_reset

   task automatic set_pat(input logic [1:0] c, input logic [15:0] lvl,
                          input logic [15:0] care, input logic [15:0] pins,
                          input logic exp);
      logic [31:0] d;
      bus(1'b1, REG_CTRL, {30'h0, c}, d);
      bus(1'b1, REG_LEVEL, {16'h0, lvl}, d);
      bus(1'b1, REG_CARE, {16'h0, care}, d);
      u_src.set_pins(pins);
      wait_n(8);
      bus(1'b0, REG_STATUS, 32'h0, d);
      chk("pattern met", {31'h0, exp}, {31'h0, d[STAT_PAT]});
   endtask : set_pat

   task automatic scen_judge();
      int i;
      int t0;
      logic [31:0] d;
      bus(1'b1, REG_REF_ADDR, 32'h0, d);
      for (i = 0; i < 64; i++)
         bus(1'b1, REG_REF_DATA, 32'h0, d);
      bus(1'b1, REG_RANGE, 32'h0000_0100, d);
      bus(1'b1, REG_CTRL, 32'h0000_5024, d);
      t0 = trig_cnt;
      send_n(16'h0200, 2, GAP);
      chk_trig("judge before crossing", t0);
      u_src.send(16'hffff, GAP);
      u_src.send(16'h0000, GAP);
      u_src.send(16'h0050, GAP);
      // Next sample is still accepted; the one after it follows too soon and must be ignored
      u_src.send(16'h0080, 2);
      u_src.send(16'h0200, GAP);
      chk_trig("judge sample too soon", t0);
      chk_trig("judge inside envelope", t0);
      u_src.send(16'h0200, GAP);
      chk_trig("judge outside envelope", t0 + 1);
      bus(1'b0, REG_STATUS, 32'h0, d);
      chk("judge hit", 32'h1, {31'h0, d[STAT_JUDGE]});
      u_src.send(16'h0050, GAP);
      bus(1'b1, REG_CTRL, 32'h0000_5004, d);
      send_n(16'h0200, 2, GAP);
      chk_trig("judge not instantaneous", t0 + 1);
      bus(1'b1, REG_CTRL, 32'h0000_8024, d);
      send_n(16'h0200, 2, GAP);
      chk_trig("judge bad time base", t0 + 1);
      bus(1'b1, REG_CTRL, 32'h0000_5024, d);
      u_src.send(16'h0050, GAP);
      bus(1'b1, REG_CTRL, 32'h0000_0024, d);
      t0 = trig_cnt;
      u_src.send(16'hffff, GAP);
      u_src.send(16'h0000, GAP);
      send_n(16'h0200, 12, GAP);
      chk_trig("judge before tick", t0);
      send_n(16'h0200, 8, GAP);
      chk_trig("judge at tick", t0 + 1);
   endtask : scen_judge

   task automatic scen_filter();
      int k;
      int t0;
      logic [31:0] d;
      lens = '{10, 20, 50, 100, 200, 500, 1000};
      for (k = 1; k < 8; k++)
      begin
         u_src.set_pins(16'h0000);
         bus(1'b1, REG_CTRL, 32'h1 | (32'(k) << CTRL_FILT_LSB), d);
         wait_n(8);
         t0 = trig_cnt;
         u_src.set_pins(16'h0001);
         wait_n(8);
         send_n(16'h0000, lens[k-1] - 1, 2);
         wait_n(6);
         chk_trig("filter one short", t0);
         u_src.set_pins(16'h0000);
         wait_n(8);
         u_src.set_pins(16'h0001);
         wait_n(8);
         send_n(16'h0000, lens[k-1], 2);
         wait_n(6);
         chk_trig("filter full count", t0 + 1);
      end
      u_src.set_pins(16'h0000);
   endtask : scen_filter

   task automatic scen_rt();
      int t0;
      logic [31:0] d;
      bus(1'b1, REG_CTRL, 32'h0000_0019, d);
      wait_n(8);
      t0 = trig_cnt;
      u_src.set_pins(16'h0001);
      wait_n(30);
      u_src.set_pins(16'h0000);
      wait_n(8);
      chk_trig("rt filter short", t0);
      u_src.set_pins(16'h0001);
      wait_n(60);
      chk_trig("rt filter full", t0 + 1);
      u_src.set_pins(16'h0000);
      bus(1'b1, REG_CTRL, 32'h0000_0059, d);
      wait_n(8);
      u_src.set_pins(16'h0001);
      wait_n(8);
      u_src.send(16'h0000, 2);
      wait_n(6);
      chk_trig("long interval one sample", t0 + 1);
      u_src.set_pins(16'h0000);
      wait_n(8);
      u_src.set_pins(16'h0001);
      wait_n(8);
      send_n(16'h0000, 2, 2);
      wait_n(6);
      chk_trig("long interval two samples", t0 + 2);
      u_src.set_pins(16'h0000);
   endtask : scen_rt

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      err_count     = 0;
      samples_checked = 0;
      reset_n       = 1'b0;
      avs_address   = '0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = '0;
      wait_n(4);
      reset_n <= 1'b1;
      wait_n(4);
      scen_reset();
      set_pat(COND_OR, 16'h0001, 16'h0001, 16'h0001, 1'b1);
      set_pat(COND_OR, 16'h0001, 16'h0001, 16'h0000, 1'b0);
      set_pat(COND_OR, 16'h0000, 16'h0001, 16'h0000, 1'b1);
      set_pat(COND_OR, 16'h0003, 16'h0003, 16'h0002, 1'b1);
      set_pat(COND_AND, 16'h0003, 16'h0003, 16'h0002, 1'b0);
      set_pat(COND_AND, 16'h0003, 16'h0003, 16'hffff, 1'b1);
      set_pat(COND_AND, 16'h0003, 16'h0003, 16'h0003, 1'b1);
      set_pat(COND_OFF, 16'h0001, 16'h0001, 16'h0001, 1'b0);
      u_src.set_pins(16'h0000);
      scen_judge();
      scen_filter();
      scen_rt();
      give_verdict();
   end
endmodule : tb_logic_judge_trigger
